// >>> rtl/i2c_addr_qualify_monitor.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "i2c_mon_regs.svh"
module i2c_addr_qualify_monitor
  import i2c_mon_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE_N,
  output logic ADDR0_MATCH,
  output logic IRQ
);

  // Address 0 comparison with optional qualifier
  function automatic logic addr0_hit(input addr7_t rx, input addr7_t adr,
                                     input addr7_t qual, input logic mode);
    logic hit;
    hit = (rx == adr);
    if (qual != 7'h00) begin
      if (qual_mode_t'(mode) == QUAL_MASK) begin
        hit = ((rx ^ adr) & ~qual) == 7'h00;
      end else begin
        hit = (rx >= adr) && (rx <= qual);
      end
    end
    return hit;
  endfunction

  // Register state
  logic [`CFG_WIDTH-1:0] config_reg, next_config_reg;
  logic [7:0] slave_addr_zero_reg, next_slave_addr_zero_reg;
  logic [7:0] addr0_qualifier, next_addr0_qualifier;
  logic [`IRQ_WIDTH-1:0] irq_status, next_irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
  logic [31:0] prdata_next;
  logic apb_access, apb_write, apb_read, addr_mapped;

  // Pin synchronisers and bus state
  logic scl_meta, sda_meta, scl_s, sda_s, scl_d, sda_d;
  logic [3:0] bit_cnt, next_bit_cnt;
  bus_byte_t shift_byte, next_shift_byte;
  logic in_frame, next_in_frame;
  logic seen_start, next_seen_start;
  logic seen_restart, next_seen_restart;
  logic first_byte, next_first_byte;
  logic addr_match, next_addr_match;

  // Monitor record and stretch
  mon_record_t mon_rec, next_mon_rec;
  logic rec_valid, next_rec_valid;
  logic scl_hold, next_scl_hold;

  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic byte_done, data_bit, ack_bit;
  logic mon_en, stretch_en, mon_read;
  logic ev_record, ev_overrun;

  assign mon_en = config_reg[`CFG_MON_EN_BIT];
  assign stretch_en = config_reg[`CFG_STRETCH_BIT];

  // Pins cross two flops before anything looks at them
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_meta <= SCL_IN;
      sda_meta <= SDA_IN;
      scl_s <= scl_meta;
      sda_s <= sda_meta;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus events; start and stop only count while clock stays high
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_cond = scl_s && scl_d && sda_d && !sda_s;
  assign stop_cond = scl_s && scl_d && !sda_d && sda_s;
  assign data_bit = scl_rise && (bit_cnt <= `LAST_DATA_BIT);
  assign ack_bit = scl_rise && (bit_cnt == `ACK_BIT_INDEX);
  assign byte_done = ack_bit && in_frame;

  // APB decode; the slave always answers in the access cycle
  assign apb_access = PSEL && PENABLE;
  assign apb_write = apb_access && PWRITE;
  assign apb_read = apb_access && !PWRITE;
  assign mon_read = apb_read && (PADDR == `OFS_MONITOR_DATA);
  assign PREADY = 1'b1;

  always_comb begin
    case (PADDR)
      `OFS_CONFIG, `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_SLAVE_ADDR_ZERO,
      `OFS_ADDR0_QUALIFIER, `OFS_MONITOR_DATA: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  // Unmapped addresses get an error answer and read zero
  assign PSLVERR = apb_access && !addr_mapped;

  // Bit and byte tracking on the bus
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shift_byte = shift_byte;
    next_in_frame = in_frame;
    next_seen_start = seen_start;
    next_seen_restart = seen_restart;
    next_first_byte = first_byte;
    next_addr_match = 1'b0;
    if (start_cond) begin
      next_bit_cnt = 4'h0;
      next_in_frame = 1'b1;
      next_first_byte = 1'b1;
      next_seen_start = 1'b1;
      next_seen_restart = in_frame; // Start inside a frame is a repeat
    end else if (stop_cond) begin
      next_in_frame = 1'b0;
      next_bit_cnt = 4'h0;
    end else if (data_bit) begin
      next_shift_byte = {shift_byte[6:0], sda_s};
      next_bit_cnt = bit_cnt + 4'h1;
    end else if (ack_bit) begin
      next_bit_cnt = 4'h0;
      if (in_frame) begin
        next_first_byte = 1'b0;
        next_seen_start = 1'b0;
        next_seen_restart = 1'b0;
        // Only the address byte after a start is compared
        next_addr_match = first_byte
          && !slave_addr_zero_reg[`ADDR_DISABLE_BIT]
          && addr0_hit(shift_byte[7:1],
                       slave_addr_zero_reg[`ADDR_FIELD_HI:`ADDR_FIELD_LO],
                       addr0_qualifier[`ADDR_FIELD_HI:`ADDR_FIELD_LO],
                       addr0_qualifier[`QUAL_MODE_BIT]);
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bit_cnt <= 4'h0;
      shift_byte <= 8'h00;
      in_frame <= 1'b0;
      seen_start <= 1'b0;
      seen_restart <= 1'b0;
      first_byte <= 1'b0;
      addr_match <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift_byte <= next_shift_byte;
      in_frame <= next_in_frame;
      seen_start <= next_seen_start;
      seen_restart <= next_seen_restart;
      first_byte <= next_first_byte;
      addr_match <= next_addr_match;
    end
  end

  assign ADDR0_MATCH = addr_match;

  // Monitor record, read release and clock stretch
  assign ev_record = byte_done && mon_en;
  assign ev_overrun = ev_record && rec_valid && !mon_read;

  always_comb begin
    next_mon_rec = mon_rec;
    next_rec_valid = rec_valid;
    if (mon_read) begin
      next_rec_valid = 1'b0;
    end
    // A new record wins over a read in the same cycle
    if (ev_record) begin
      next_mon_rec[`MON_NACK_BIT] = sda_s;
      next_mon_rec[`MON_RESTART_BIT] = seen_restart;
      next_mon_rec[`MON_START_BIT] = seen_start;
      next_mon_rec[`MON_BYTE_HI:0] = shift_byte;
      next_rec_valid = 1'b1;
    end
    // Pull clock low only once it is already low, so no high pulse is cut short
    next_scl_hold = mon_en && stretch_en && next_rec_valid
      && (scl_hold || !scl_s || scl_fall);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mon_rec <= `RST_MON_REC;
      rec_valid <= 1'b0;
      scl_hold <= 1'b0;
    end else begin
      mon_rec <= next_mon_rec;
      rec_valid <= next_rec_valid;
      scl_hold <= next_scl_hold;
    end
  end

  // Open-drain clock: enable low means the pin is driven low
  assign SCL_OUT = 1'b0;
  assign SCL_OE_N = !scl_hold;

  // Software registers and sticky interrupt flags
  always_comb begin
    next_config_reg = config_reg;
    next_slave_addr_zero_reg = slave_addr_zero_reg;
    next_addr0_qualifier = addr0_qualifier;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (apb_write) begin
      case (PADDR)
        `OFS_CONFIG: next_config_reg = PWDATA[`CFG_WIDTH-1:0];
        `OFS_IRQ_MASK: next_irq_mask = PWDATA[`IRQ_WIDTH-1:0];
        `OFS_IRQ_STATUS: next_irq_status = irq_status & ~PWDATA[`IRQ_WIDTH-1:0];
        `OFS_SLAVE_ADDR_ZERO: next_slave_addr_zero_reg = PWDATA[7:0];
        `OFS_ADDR0_QUALIFIER: next_addr0_qualifier = PWDATA[7:0];
        default: next_config_reg = config_reg; // Monitor data ignores writes
      endcase
    end
    // Hardware sets win over a same-cycle clear
    if (addr_match) begin
      next_irq_status[`IRQ_ADDR0_BIT] = 1'b1;
    end
    if (ev_record) begin
      next_irq_status[`IRQ_RECORD_BIT] = 1'b1;
    end
    if (ev_overrun) begin
      next_irq_status[`IRQ_OVERRUN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      config_reg <= `RST_CONFIG;
      slave_addr_zero_reg <= `RST_SLAVE_ADDR_ZERO;
      addr0_qualifier <= `RST_ADDR0_QUALIFIER;
      irq_status <= `RST_IRQ;
      irq_mask <= `RST_IRQ;
    end else begin
      config_reg <= next_config_reg;
      slave_addr_zero_reg <= next_slave_addr_zero_reg;
      addr0_qualifier <= next_addr0_qualifier;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  // Read mux; reserved bits read zero
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (PADDR)
      `OFS_CONFIG: prdata_next[`CFG_WIDTH-1:0] = config_reg;
      `OFS_IRQ_STATUS: prdata_next[`IRQ_WIDTH-1:0] = irq_status;
      `OFS_IRQ_MASK: prdata_next[`IRQ_WIDTH-1:0] = irq_mask;
      `OFS_SLAVE_ADDR_ZERO: prdata_next[7:0] = slave_addr_zero_reg;
      `OFS_ADDR0_QUALIFIER: prdata_next[7:0] = addr0_qualifier;
      `OFS_MONITOR_DATA: prdata_next[`MON_NACK_BIT:0] = mon_rec;
      default: prdata_next = 32'h0000_0000;
    endcase
  end

  // Read data is combinational from state so it is valid in the access cycle
  assign PRDATA = apb_read ? prdata_next : 32'h0000_0000;

endmodule

// >>> rtl/i2c_mon_regs.svh
`ifndef I2C_MON_REGS_SVH
`define I2C_MON_REGS_SVH

// Register byte offsets
`define OFS_CONFIG 12'h000
`define OFS_IRQ_STATUS 12'h004
`define OFS_IRQ_MASK 12'h008
`define OFS_SLAVE_ADDR_ZERO 12'h048
`define OFS_ADDR0_QUALIFIER 12'h058
`define OFS_MONITOR_DATA 12'h080

// Configuration fields
`define CFG_MON_EN_BIT 0
`define CFG_STRETCH_BIT 1
`define CFG_WIDTH 2

// Slave address 0 and qualifier fields
`define ADDR_FIELD_HI 7
`define ADDR_FIELD_LO 1
`define ADDR_DISABLE_BIT 0
`define QUAL_MODE_BIT 0

// Monitor record fields
`define MON_NACK_BIT 10
`define MON_RESTART_BIT 9
`define MON_START_BIT 8
`define MON_BYTE_HI 7

// Interrupt status and mask bits
`define IRQ_ADDR0_BIT 0
`define IRQ_RECORD_BIT 1
`define IRQ_OVERRUN_BIT 2
`define IRQ_WIDTH 3

// Reset values
`define RST_CONFIG 2'h0
`define RST_SLAVE_ADDR_ZERO 8'h01
`define RST_ADDR0_QUALIFIER 8'h00
`define RST_IRQ 3'h0
`define RST_MON_REC 11'h000

// Bit counter: eight data bits then the acknowledge bit
`define LAST_DATA_BIT 4'h7
`define ACK_BIT_INDEX 4'h8

`endif

// >>> rtl/i2c_mon_pkg.sv
package i2c_mon_pkg;

  // Qualifier interpretation selected by the mode bit
  typedef enum logic {
    QUAL_MASK,
    QUAL_EXTEND
  } qual_mode_t;

  typedef logic [6:0] addr7_t;
  typedef logic [7:0] bus_byte_t;
  typedef logic [10:0] mon_record_t;

endpackage

// >>> sim/i2c_mon_checker_assertions.sv
`timescale 1ns/10ps
module i2c_mon_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic SCL_IN,
  input wire logic SCL_OE_N,
  input wire logic ADDR0_MATCH,
  input wire logic IRQ
);
  logic acc;
  // Access phase of an APB transfer
  assign acc = PSEL && PENABLE;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_rec_write_ok: assert property (acc && PWRITE && PADDR == 12'h080 |-> !PSLVERR)
    else $error("record write refused");
  a_unmapped_err: assert property (acc && PADDR == 12'h0FC |-> PSLVERR)
    else $error("unmapped access accepted");
  a_setup_quiet: assert property (PSEL && !PENABLE |-> !PSLVERR && PRDATA == 32'h0)
    else $error("setup cycle answered");
  a_read_release: assert property (acc && !PWRITE && PADDR == 12'h080 |=> SCL_OE_N)
    else $error("clock held after record read");
  // Stretching may only extend a low phase the bus already began
  a_stretch_low: assert property ($fell(SCL_OE_N) |-> !SCL_IN && !$past(SCL_IN))
    else $error("clock pulled while high");
  a_match_pulse: assert property (ADDR0_MATCH |=> !ADDR0_MATCH)
    else $error("match pulse too long");
  a_irq_clear: assert property ($fell(IRQ) |-> $past(acc && PWRITE))
    else $error("interrupt fell without write");
  a_reset_idle: assert property ($past(RST) |-> SCL_OE_N && !IRQ && !ADDR0_MATCH)
    else $error("outputs busy after reset");
endmodule

bind i2c_addr_qualify_monitor i2c_mon_checker chk (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .SCL_IN(SCL_IN), .SCL_OE_N(SCL_OE_N), .ADDR0_MATCH(ADDR0_MATCH), .IRQ(IRQ));

// >>> sim/i2c_bus_model.sv
`timescale 1ns/10ps
module i2c_bus_model (
  input wire logic scl_hold_n,
  output logic scl_line,
  output logic sda_line,
  output logic hung
);
  logic scl_rel = 1'b1;
  logic sda_drv = 1'b1;
  initial hung = 1'b0;
  // Both lines pulled up; SCL is low whenever either party pulls it
  assign scl_line = scl_rel & scl_hold_n;
  assign sda_line = sda_drv;
  // One 800 ns bit; a stretching device delays the high phase, bounded
  task automatic pulse();
    int n;
    #400 scl_rel = 1'b1;
    for (n = 0; n < 500 && !scl_line; n++) #100;
    hung |= !scl_line;
    #400 scl_rel = 1'b0;
  endtask
  // Start and repeated start both drop SDA while SCL is high
  task automatic start();
    #200 sda_drv = 1'b1;
    #200 scl_rel = 1'b1;
    #400 sda_drv = 1'b0;
    #400 scl_rel = 1'b0;
  endtask
  task automatic stop();
    #200 sda_drv = 1'b0;
    #200 scl_rel = 1'b1;
    #400 sda_drv = 1'b1;
    #400;
  endtask
  // Eight bits MSB first, then the receiver's answer on the ninth pulse
  task automatic send(input logic [7:0] b, input logic nack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      pulse();
    end
    sda_drv = nack;
    pulse();
  endtask
endmodule

// >>> sim/test_i2c_addr_qualify_monitor.sv
`timescale 1ns/10ps
module test_i2c_addr_qualify_monitor;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, r; logic e;} reg_row_t;
  typedef struct {logic [7:0] sa, q; logic [6:0] a; logic m;} qual_row_t;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, rdat;
  logic PREADY, PSLVERR, SCL_IN, SDA_IN, SCL_OE_N, ADDR0_MATCH, IRQ, rerr;
  logic SCL_OUT;
  int err_count = 0;
  int comparisons = 0;
  int hits = 0;
  int h0;
  // Reset values, a qualifier round trip, a write to the read-only record, a hole
  reg_row_t rows[7] = '{'{1'h0, 12'h048, 32'h0, 32'h1, 1'h0},
    '{1'h0, 12'h058, 32'h0, 32'h0, 1'h0}, '{1'h1, 12'h058, 32'hAB, 32'h0, 1'h0},
    '{1'h0, 12'h058, 32'h0, 32'hAB, 1'h0}, '{1'h1, 12'h080, 32'h7FF, 32'h0, 1'h0},
    '{1'h0, 12'h080, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h0FC, 32'h0, 32'h0, 1'h1}};
  // Exact, disabled, mask and range cases; a matched address is acknowledged
  qual_row_t quals[8] = '{'{8'hA0, 8'h00, 7'h50, 1'h1}, '{8'hA0, 8'h00, 7'h51, 1'h0},
    '{8'hA1, 8'h00, 7'h50, 1'h0}, '{8'hA0, 8'h06, 7'h53, 1'h1}, '{8'hA0, 8'h06, 7'h54, 1'h0},
    '{8'hA0, 8'hB1, 7'h58, 1'h1}, '{8'hA0, 8'hB1, 7'h59, 1'h0}, '{8'hA0, 8'hB1, 7'h4F, 1'h0}};

  i2c_addr_qualify_monitor dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N),
    .ADDR0_MATCH(ADDR0_MATCH), .IRQ(IRQ));
  i2c_bus_model bus (.scl_hold_n(SCL_OE_N), .scl_line(SCL_IN), .sda_line(SDA_IN), .hung());

  always #50 CLK = ~CLK;
  // Count match pulses so each frame can be judged afterwards
  always @(posedge CLK) if (ADDR0_MATCH === 1'b1) hits++;

  task automatic complete_run();
    if (bus.hung === 1'b1) err_count++;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; write data is driven as given, PREADY awaited up to 20 cycles
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n == 20) begin
      err_count++;
      complete_run();
    end
  endtask

  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check(rdat, rows[i].r);
      check({31'h0, rerr}, {31'h0, rows[i].e});
    end
    $display("register rows done");
    apb(1'h1, 12'h000, 32'h1);
    foreach (quals[i]) begin
      apb(1'h1, 12'h048, {24'h0, quals[i].sa});
      apb(1'h1, 12'h058, {24'h0, quals[i].q});
      h0 = hits;
      bus.start();
      bus.send({quals[i].a, 1'b0}, !quals[i].m);
      bus.stop();
      check(32'(hits - h0), {31'h0, quals[i].m});
      apb(1'h0, 12'h080, 32'h0);
      check(rdat, {21'h0, !quals[i].m, 2'b01, quals[i].a, 1'b0});
    end
    $display("qualifier rows done");
    // Three bytes unread: only the last survives and the overrun is flagged
    bus.start();
    bus.send(8'hA0, 1'b0);
    bus.send(8'h3C, 1'b0);
    bus.send(8'h5A, 1'b1);
    apb(1'h0, 12'h080, 32'h0);
    check(rdat, 32'h45A);
    @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    apb(1'h1, 12'h008, 32'h4);
    @(posedge CLK);
    check({31'h0, IRQ}, 32'h1);
    apb(1'h1, 12'h004, 32'h4);
    @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    // Start again without a stop in between
    bus.start();
    bus.send(8'hA1, 1'b1);
    bus.stop();
    apb(1'h0, 12'h080, 32'h0);
    check(rdat & 32'h6FF, 32'h6A1);
    $display("overwrite and restart done");
    apb(1'h1, 12'h000, 32'h0);
    bus.start();
    bus.send(8'h22, 1'b0);
    bus.stop();
    apb(1'h0, 12'h080, 32'h0);
    check({24'h0, rdat[7:0]}, 32'hA1);
    $display("disabled monitor done");
    // Unread record with stretching on holds the clock until it is read
    apb(1'h1, 12'h000, 32'h3);
    bus.start();
    bus.send(8'h20, 1'b0);
    repeat (20) @(posedge CLK);
    check({31'h0, SCL_OE_N}, 32'h0);
    check({31'h0, SCL_OUT}, 32'h0);
    apb(1'h0, 12'h080, 32'h0);
    check(rdat, 32'h120);
    repeat (2) @(posedge CLK);
    check({31'h0, SCL_OE_N}, 32'h1);
    bus.stop();
    $display("stretch done");
    // Reset in mid-run returns the registers and the clock pin to idle
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    check({31'h0, SCL_OE_N}, 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    check(rdat, 32'h0);
    apb(1'h0, 12'h048, 32'h0);
    check(rdat, 32'h1);
    check({31'h0, IRQ}, 32'h0);
    $display("mid-run reset done");
    complete_run();
  end
endmodule
